/* File: rstseq_board_model.sv */
// Board side model: power-on supervisor, lock sources, straps, open-drain reset lines.
// Assumes everything runs on the core clock and both reset lines carry pull-ups.
`timescale 1ns/10ps
module rstseq_board_model
(
	input  wire logic                                  core_clk,
	input  wire logic                                  hard_oe,
	input  wire logic                                  soft_oe,
	input  wire logic                                  cfg_oe,
	input  wire logic [rstseq_pkg::CFG_W-1:0]          cfg_out,
	output logic                                       por_n,
	output logic                                       host,
	output logic      [rstseq_pkg::PLL_RATIO_W-1:0]    ratio,
	output logic                                       pll_ok,
	output logic      [rstseq_pkg::NUM_DLL-1:0]        dll_ok,
	output logic                                       hard_in,
	output logic                                       soft_in,
	output logic      [rstseq_pkg::CFG_W-1:0]          cfg_in
);
	logic                           pull_h;
	logic                           pull_s;
	logic [rstseq_pkg::CFG_W-1:0]   strap;

	// ==========================================================
	// Wires
	initial
	begin
		por_n = 1'h0;
		host = 1'h0;
		ratio = 4'h0;
		pll_ok = 1'h0;
		dll_ok = 2'h0;
		pull_h = 1'h0;
		pull_s = 1'h0;
		strap = 4'h0;
	end
	assign hard_in = ~(hard_oe | pull_h);
	assign soft_in = ~(soft_oe | pull_s);
	assign cfg_in = cfg_oe ? cfg_out : strap;

	// ==========================================================
	// Power-on cycle with straps settled well ahead of release
	task automatic por(input logic h, input logic [3:0] c, input logic [3:0] r, input int dly);
		@(posedge core_clk);
		por_n <= 1'h0;
		pll_ok <= 1'h0;
		dll_ok <= 2'h0;
		host <= h;
		strap <= c;
		ratio <= r;
		repeat (40) @(posedge core_clk);
		por_n <= 1'h1;
		repeat (10) @(posedge core_clk);
		pll_ok <= 1'h1;
		repeat (dly) @(posedge core_clk);
		dll_ok <= 2'h3;
	endtask

	// ==========================================================
	// External agent pulls one line low for a number of cycles
	task automatic pull(input logic hs, input int n);
		@(posedge core_clk);
		pull_h <= hs;
		pull_s <= ~hs;
		repeat (n) @(posedge core_clk);
		pull_h <= 1'h0;
		pull_s <= 1'h0;
	endtask
endmodule

/* File: rstseq_core.sv */
// Reset initialization sequencer: power-on, hard and soft reset flow.
// Assumes synchronous pins, open-drain wiring outside, one core clock.
`timescale 1ns/10ps
module rstseq_core
#(
	parameter int DLL_LOCK_MAX_CYC = rstseq_pkg::DLL_LOCK_MAX_CYC
)
(
	input  wire logic                                  core_clk,
	input  wire logic                                  rst_n,
	input  wire logic                                  power_on_reset_n,
	input  wire logic                                  host_mode_strap,
	input  wire logic [rstseq_pkg::PLL_RATIO_W-1:0]    sys_pll_ratio_strap,
	input  wire logic                                  pll_locked,
	input  wire logic [rstseq_pkg::NUM_DLL-1:0]        dll_locked,
	input  wire logic                                  hard_reset_n_in,
	output logic                                       hard_reset_n_out,
	output logic                                       hard_reset_n_oe,
	input  wire logic                                  soft_reset_n_in,
	output logic                                       soft_reset_n_out,
	output logic                                       soft_reset_n_oe,
	input  wire logic [rstseq_pkg::CFG_W-1:0]          cfg_pin_in,
	output logic      [rstseq_pkg::CFG_W-1:0]          cfg_pin_out,
	output logic                                       cfg_pin_oe,
	output logic                                       internal_reset_n,
	output logic                                       primary_clock_sel,
	output logic      [rstseq_pkg::CFG_SRC_W-1:0]      reset_source_sel,
	output logic                                       input_clock_divide_select,
	output logic      [rstseq_pkg::PLL_RATIO_W-1:0]    sys_pll_ratio,
	output logic                                       lock_timeout
);

	rstseq_pkg::rstseq_state_e             state_reg;
	rstseq_pkg::rstseq_state_e             state_next;
	logic [rstseq_pkg::TICK_W-1:0]         tick_cnt_reg;
	logic [rstseq_pkg::TICK_W-1:0]         tick_cnt_next;
	logic [rstseq_pkg::EXT_W-1:0]          ext_cnt_reg;
	logic [rstseq_pkg::EXT_W-1:0]          ext_cnt_next;
	logic [rstseq_pkg::LOCK_W-1:0]         lock_cnt_reg;
	logic [rstseq_pkg::LOCK_W-1:0]         lock_cnt_next;
	logic [1:0]                            cfg_cnt_reg;
	logic [1:0]                            cfg_cnt_next;
	logic                                  hard_oe_reg;
	logic                                  hard_oe_next;
	logic                                  soft_oe_reg;
	logic                                  soft_oe_next;
	logic                                  cfg_oe_reg;
	logic                                  cfg_oe_next;
	logic                                  int_rst_n_reg;
	logic                                  int_rst_n_next;
	logic                                  timeout_reg;
	logic                                  timeout_next;
	logic                                  por_prev_reg;
	logic [rstseq_pkg::CFG_W-1:0]          cfg_cap_reg;
	logic [rstseq_pkg::CFG_W-1:0]          cfg_cap_next;
	logic [rstseq_pkg::PLL_RATIO_W-1:0]    ratio_reg;
	logic [rstseq_pkg::PLL_RATIO_W-1:0]    ratio_next;
	logic                                  host_reg;
	logic                                  host_next;
	logic                                  ext_low;
	logic                                  tick;
	logic [rstseq_pkg::TICK_W-1:0]         hold_ticks_reg;

	rstseq_tick_if tif ();

	// ==========================================================
	// Sync period tick
	assign tif.host_mode = host_reg;
	assign tif.div_sel   = cfg_cap_reg[rstseq_pkg::CFG_DIV_BIT];
	assign tick          = tif.tick;

	rstseq_tick_gen u_tick
	(
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tif      (tif)
	);

	function automatic logic cnt_hit(input logic [rstseq_pkg::TICK_W-1:0] cnt, input int limit);
		cnt_hit = (cnt == rstseq_pkg::TICK_W'(limit - 1));
	endfunction

	localparam logic [rstseq_pkg::LOCK_W-1:0] LOCK_W_MAX = rstseq_pkg::LOCK_W'(DLL_LOCK_MAX_CYC - 1);

	// ==========================================================
	// Strap capture
	always_comb
	begin
		cfg_cap_next = cfg_cap_reg;
		ratio_next   = ratio_reg;
		host_next    = host_reg;
		if (power_on_reset_n && !por_prev_reg)
		begin
			cfg_cap_next = cfg_pin_in;
			ratio_next   = sys_pll_ratio_strap;
			host_next    = host_mode_strap;
		end
	end

	// ==========================================================
	// Sequencer
	assign ext_low = (!hard_reset_n_in && !hard_oe_reg) || (!soft_reset_n_in && !soft_oe_reg);

	always_comb
	begin
		state_next     = state_reg;
		tick_cnt_next  = tick_cnt_reg;
		ext_cnt_next   = ext_cnt_reg;
		lock_cnt_next  = lock_cnt_reg;
		hard_oe_next   = hard_oe_reg;
		soft_oe_next   = soft_oe_reg;
		int_rst_n_next = int_rst_n_reg;
		timeout_next   = timeout_reg;
		case (state_reg)
			rstseq_pkg::ST_POR:
			begin
				hard_oe_next   = 1'b1;
				soft_oe_next   = 1'b1;
				int_rst_n_next = 1'b0;
				lock_cnt_next  = '0;
				timeout_next   = 1'b0;
				if (power_on_reset_n)
					state_next = rstseq_pkg::ST_PLL;
			end
			rstseq_pkg::ST_PLL:
			begin
				lock_cnt_next = lock_cnt_reg + 1'b1;
				if (pll_locked)
				begin
					lock_cnt_next = '0;
					state_next    = rstseq_pkg::ST_DLL;
				end
				else if (lock_cnt_reg == rstseq_pkg::LOCK_W'(rstseq_pkg::PLL_LOCK_CYC - 1))
					timeout_next = 1'b1;
			end
			rstseq_pkg::ST_DLL:
			begin
				lock_cnt_next = lock_cnt_reg + 1'b1;
				if (&dll_locked)
				begin
					int_rst_n_next = 1'b1;
					tick_cnt_next  = '0;
					state_next     = rstseq_pkg::ST_ASSERT;
				end
				else if (lock_cnt_reg == LOCK_W_MAX)
					timeout_next = 1'b1;
			end
			rstseq_pkg::ST_ASSERT:
			begin
				hard_oe_next = 1'b1;
				soft_oe_next = 1'b1;
				if (tick)
				begin
					tick_cnt_next = tick_cnt_reg + 1'b1;
					if (cnt_hit(tick_cnt_reg, rstseq_pkg::OUT_ASSERT_TICKS))
					begin
						hard_oe_next  = 1'b0;
						tick_cnt_next = '0;
						state_next    = rstseq_pkg::ST_SOFT;
					end
				end
			end
			rstseq_pkg::ST_SOFT:
			begin
				if (tick)
				begin
					tick_cnt_next = tick_cnt_reg + 1'b1;
					if (cnt_hit(tick_cnt_reg, rstseq_pkg::HARD_TO_SOFT_TICKS))
					begin
						soft_oe_next = 1'b0;
						state_next   = rstseq_pkg::ST_RUN;
					end
				end
			end
			rstseq_pkg::ST_RUN:
			begin
				if (!ext_low)
					ext_cnt_next = '0;
				else if (tick)
				begin
					ext_cnt_next = ext_cnt_reg + 1'b1;
					if (ext_cnt_reg == rstseq_pkg::EXT_W'(rstseq_pkg::EXT_ASSERT_TICKS - 1))
					begin
						ext_cnt_next   = '0;
						hard_oe_next   = 1'b1;
						soft_oe_next   = 1'b1;
						int_rst_n_next = 1'b0;
						lock_cnt_next  = '0;
						state_next     = rstseq_pkg::ST_PLL;
					end
				end
			end
			default:
				state_next = rstseq_pkg::ST_POR;
		endcase
		if (!power_on_reset_n)
			state_next = rstseq_pkg::ST_POR;
	end

	// ==========================================================
	// Strap pin drive
	always_comb
	begin
		cfg_oe_next  = cfg_oe_reg;
		cfg_cnt_next = cfg_cnt_reg;
		if (hard_oe_next || !hard_reset_n_in)
		begin
			cfg_oe_next  = 1'b0;
			cfg_cnt_next = '0;
		end
		else if (!cfg_oe_reg && tick)
		begin
			if (cfg_cnt_reg == 2'(rstseq_pkg::CFG_RESUME_TICKS))
				cfg_oe_next = 1'b1;
			else
				cfg_cnt_next = cfg_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg     <= rstseq_pkg::ST_POR;
			tick_cnt_reg  <= '0;
			ext_cnt_reg   <= '0;
			lock_cnt_reg  <= '0;
			cfg_cnt_reg   <= '0;
			hard_oe_reg   <= 1'b1;
			soft_oe_reg   <= 1'b1;
			cfg_oe_reg    <= 1'b0;
			int_rst_n_reg <= 1'b0;
			timeout_reg   <= 1'b0;
			por_prev_reg  <= 1'b0;
			cfg_cap_reg   <= rstseq_pkg::CFG_RESET;
			ratio_reg     <= rstseq_pkg::PLL_RATIO_RESET;
			host_reg      <= 1'b1;
		end
		else
		begin
			state_reg     <= state_next;
			tick_cnt_reg  <= tick_cnt_next;
			ext_cnt_reg   <= ext_cnt_next;
			lock_cnt_reg  <= lock_cnt_next;
			cfg_cnt_reg   <= cfg_cnt_next;
			hard_oe_reg   <= hard_oe_next;
			soft_oe_reg   <= soft_oe_next;
			cfg_oe_reg    <= cfg_oe_next;
			int_rst_n_reg <= int_rst_n_next;
			timeout_reg   <= timeout_next;
			por_prev_reg  <= power_on_reset_n;
			cfg_cap_reg   <= cfg_cap_next;
			ratio_reg     <= ratio_next;
			host_reg      <= host_next;
		end
	end

	// ==========================================================
	// Outputs
	assign hard_reset_n_out          = 1'b0;
	assign soft_reset_n_out          = 1'b0;
	assign hard_reset_n_oe           = hard_oe_reg;
	assign soft_reset_n_oe           = soft_oe_reg;
	assign cfg_pin_out               = cfg_cap_reg;
	assign cfg_pin_oe                = cfg_oe_reg;
	assign internal_reset_n          = int_rst_n_reg;
	assign primary_clock_sel         = ~host_reg;
	assign reset_source_sel          = cfg_cap_reg[rstseq_pkg::CFG_SRC_LSB +: rstseq_pkg::CFG_SRC_W];
	assign input_clock_divide_select = cfg_cap_reg[rstseq_pkg::CFG_DIV_BIT];
	assign sys_pll_ratio             = ratio_reg;
	assign lock_timeout              = timeout_reg;

	// ==========================================================
	// Checks
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			hold_ticks_reg <= '0;
		else if (!hard_oe_reg)
			hold_ticks_reg <= '0;
		else if (tick && !(&hold_ticks_reg))
			hold_ticks_reg <= hold_ticks_reg + 1'b1;
	end

	property p_hold_512;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(hard_oe_reg) |-> ($past(hold_ticks_reg) >= 10'(rstseq_pkg::OUT_ASSERT_TICKS - 1));
	endproperty
	a_hold_512: assert property (p_hold_512) else $error("hard reset released too early");

	property p_soft_after;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(hard_oe_reg) |-> soft_oe_reg [*8];
	endproperty
	a_soft_after: assert property (p_soft_after) else $error("soft reset released too soon after hard");

	property p_ext_start;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == rstseq_pkg::ST_RUN && power_on_reset_n && ext_low && tick && ext_cnt_reg == 6'h1F)
		|=> (hard_oe_reg && soft_oe_reg && !internal_reset_n);
	endproperty
	a_ext_start: assert property (p_ext_start) else $error("external reset not honoured");

	property p_cfg_off;
		@(posedge core_clk) disable iff (!rst_n)
		hard_oe_reg |-> !cfg_pin_oe;
	endproperty
	a_cfg_off: assert property (p_cfg_off) else $error("straps driven during hard reset");

	property p_cfg_on;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(hard_oe_reg) |-> !cfg_pin_oe [*2];
	endproperty
	a_cfg_on: assert property (p_cfg_on) else $error("strap drive resumed too early");

	property p_capture;
		@(posedge core_clk) disable iff (!rst_n)
		(power_on_reset_n && !por_prev_reg) |=>
		(reset_source_sel == $past(cfg_pin_in[2:0]) && sys_pll_ratio == $past(sys_pll_ratio_strap)
		&& primary_clock_sel == !$past(host_mode_strap));
	endproperty
	a_capture: assert property (p_capture) else $error("straps not captured at power-on release");

	property p_dll_timeout;
		@(posedge core_clk) disable iff (!rst_n)
		(state_reg == rstseq_pkg::ST_DLL && power_on_reset_n && !(&dll_locked) && lock_cnt_reg == LOCK_W_MAX)
		|=> lock_timeout;
	endproperty
	a_dll_timeout: assert property (p_dll_timeout) else $error("DLL lock timeout not flagged");

	property p_int_first;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(hard_oe_reg) |-> (internal_reset_n && $past(internal_reset_n));
	endproperty
	a_int_first: assert property (p_int_first) else $error("internal reset still low at output release");

	property p_locks;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(internal_reset_n) |-> &$past(dll_locked);
	endproperty
	a_locks: assert property (p_locks) else $error("internal reset released without DLL lock");

endmodule

/* File: rstseq_core_test.sv */
// Self-checking bench of the reset sequencer with the board model.
// Assumes the design core and package are compiled first.
`timescale 1ns/10ps
module rstseq_core_test;
	logic        core_clk;
	logic        rst_n;
	logic        power_on_reset_n;
	logic        host_mode_strap;
	logic [3:0]  sys_pll_ratio_strap;
	logic        pll_locked;
	logic [1:0]  dll_locked;
	logic        hard_reset_n_in;
	logic        hard_reset_n_out;
	logic        hard_oe;
	logic        soft_reset_n_in;
	logic        soft_reset_n_out;
	logic        soft_oe;
	logic [3:0]  cfg_pin_in;
	logic [3:0]  cfg_pin_out;
	logic        cfg_oe;
	logic        internal_reset_n;
	logic        primary_clock_sel;
	logic [2:0]  reset_source_sel;
	logic        input_clock_divide_select;
	logic [3:0]  sys_pll_ratio;
	logic        lock_timeout;
	int          failures;
	int          checks;

	always #20 core_clk = ~core_clk;

	rstseq_core #(.DLL_LOCK_MAX_CYC(200)) rstseq_core_inst
	(
		.core_clk(core_clk), .rst_n(rst_n), .power_on_reset_n(power_on_reset_n),
		.host_mode_strap(host_mode_strap), .sys_pll_ratio_strap(sys_pll_ratio_strap),
		.pll_locked(pll_locked), .dll_locked(dll_locked), .hard_reset_n_in(hard_reset_n_in),
		.hard_reset_n_out(hard_reset_n_out), .hard_reset_n_oe(hard_oe), .soft_reset_n_in(soft_reset_n_in),
		.soft_reset_n_out(soft_reset_n_out), .soft_reset_n_oe(soft_oe), .cfg_pin_in(cfg_pin_in),
		.cfg_pin_out(cfg_pin_out), .cfg_pin_oe(cfg_oe), .internal_reset_n(internal_reset_n),
		.primary_clock_sel(primary_clock_sel), .reset_source_sel(reset_source_sel),
		.input_clock_divide_select(input_clock_divide_select), .sys_pll_ratio(sys_pll_ratio),
		.lock_timeout(lock_timeout)
	);

	rstseq_board_model rstseq_board_model_inst
	(
		.core_clk(core_clk), .hard_oe(hard_oe), .soft_oe(soft_oe), .cfg_oe(cfg_oe), .cfg_out(cfg_pin_out),
		.por_n(power_on_reset_n), .host(host_mode_strap), .ratio(sys_pll_ratio_strap), .pll_ok(pll_locked),
		.dll_ok(dll_locked), .hard_in(hard_reset_n_in), .soft_in(soft_reset_n_in), .cfg_in(cfg_pin_in)
	);

	// ==========================================================
	// Helpers
	task automatic report_and_stop();
		$display("Checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input bit ok, input string msg);
		checks++;
		if (!ok)
		begin
			failures++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	function automatic int period(input logic h, input logic [3:0] c);
		return (h && c[rstseq_pkg::CFG_DIV_BIT]) ? 2 : 1;
	endfunction

	function automatic logic sig(input int s);
		case (s)
			0: return internal_reset_n;
			1: return hard_oe;
			2: return soft_oe;
			default: return cfg_oe;
		endcase
	endfunction

	task automatic wait_sig(input int s, input logic v, input int lim, output int n);
		n = 0;
		while (sig(s) !== v && n < lim)
		begin
			@(negedge core_clk);
			n++;
		end
		if (n >= lim)
		begin
			chk(1'b0, "wait ran out");
			report_and_stop();
		end
	endtask

	// ==========================================================
	// Flow after locks, then captured values
	task automatic flow_tail(input logic h, input logic [3:0] c, input logic [3:0] r);
		int p;
		int n;
		int m;
		int k;
		p = period(h, c);
		wait_sig(0, 1'h1, 16, n);
		wait_sig(1, 1'h0, 600 * p, n);
		chk(n > 512 * p - p && n <= 512 * p + 4, "hard release time");
		chk(cfg_oe === 1'h0, "straps driven during reset");
		wait_sig(3, 1'h1, 40 * p, k);
		chk(k > p && k <= 2 * p + 1, "strap drive resume time");
		wait_sig(2, 1'h0, 40 * p, m);
		chk(m + k >= 16 * p && m + k <= 16 * p + 4, "soft release gap");
		chk(reset_source_sel === c[2:0] && input_clock_divide_select === c[3], "strap capture");
		chk(primary_clock_sel === ~h, "clock source");
		chk(sys_pll_ratio === r, "pll ratio");
		chk(cfg_pin_out === c, "strap re-drive value");
		chk(hard_reset_n_out === 1'h0 && soft_reset_n_out === 1'h0, "line drive level");
	endtask

	task automatic run_flow(input logic h, input logic [3:0] c, input logic [3:0] r, input int dly);
		rstseq_board_model_inst.por(h, c, r, dly);
		@(negedge core_clk);
		chk(internal_reset_n === 1'h0 && hard_oe === 1'h1 && cfg_oe === 1'h0, "early release");
		chk(lock_timeout === (dly > 200), "lock timeout flag");
		flow_tail(h, c, r);
		$display("Test flow host %0d cfg %h done", h, c);
	endtask

	task automatic ext_pull(input logic hs, input int t);
		fork
			rstseq_board_model_inst.pull(hs, t);
			begin
				repeat (3) @(negedge core_clk);
				chk(cfg_oe === !hs, "strap drive state during line pull");
			end
		join
		@(negedge core_clk);
		chk(internal_reset_n === (t < 32) && hard_oe === (t >= 32), "external reset response");
		$display("Test external pull %0d ticks done", t);
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		void'($urandom(2));
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		run_flow(1'h1, 4'hF, 4'h5, 20);
		run_flow(1'h0, 4'h8, 4'hA, 300);
		ext_pull(1'h1, 20);
		ext_pull(1'h0, 32);
		flow_tail(1'h0, 4'h8, 4'hA);
		repeat (3)
			run_flow(1'($urandom_range(1, 0)), 4'($urandom), 4'($urandom), 20);
		report_and_stop();
	end
endmodule

/* File: rstseq_pkg.sv */
// Constants, field layout and state encoding of the reset initialization sequencer.
// Assumes one core clock at 25 MHz; all pins are synchronous to it.
package rstseq_pkg;

	// ==========================================================
	// Clock
	localparam int CORE_CLK_HZ        = 25_000_000;

	// ==========================================================
	// Sync clock period counts
	localparam int EXT_ASSERT_TICKS   = 32;
	localparam int OUT_ASSERT_TICKS   = 512;
	localparam int HARD_TO_SOFT_TICKS = 16;
	localparam int CFG_RESUME_TICKS   = 1;

	// ==========================================================
	// Lock times
	localparam int PLL_LOCK_US        = 100;
	localparam int PLL_LOCK_CYC       = (PLL_LOCK_US * (CORE_CLK_HZ / 1_000_000));
	localparam int DLL_LOCK_MIN_CYC   = 7680;
	localparam int DLL_LOCK_MAX_CYC   = 122880;
	localparam int NUM_DLL            = 2;

	// ==========================================================
	// Widths and strap layout
	localparam int TICK_W             = 10;
	localparam int EXT_W              = 6;
	localparam int LOCK_W             = 17;
	localparam int CFG_W              = 4;
	localparam int CFG_SRC_LSB        = 0;
	localparam int CFG_SRC_W          = 3;
	localparam int CFG_DIV_BIT        = 3;
	localparam int PLL_RATIO_W        = 4;
	localparam logic [CFG_W-1:0]       CFG_RESET       = 4'h0;
	localparam logic [PLL_RATIO_W-1:0] PLL_RATIO_RESET = 4'h0;

	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0]
	{
		ST_POR    = 3'b000,
		ST_PLL    = 3'b001,
		ST_DLL    = 3'b010,
		ST_ASSERT = 3'b011,
		ST_SOFT   = 3'b100,
		ST_RUN    = 3'b101
	} rstseq_state_e;

endpackage

/* File: rstseq_tick_gen.sv */
// Sync clock period tick generator.
// Assumes host mode and divide select are stable while reset flow runs.
`timescale 1ns/10ps
module rstseq_tick_gen
(
	input wire logic    core_clk,
	input wire logic    rst_n,
	rstseq_tick_if.gen  tif
);

	logic phase_reg;
	logic phase_next;
	logic tick_reg;
	logic tick_next;

	// ==========================================================
	// Divider
	always_comb
	begin
		if (tif.host_mode && tif.div_sel)
		begin
			phase_next = ~phase_reg;
			tick_next  = phase_reg;
		end
		else
		begin
			phase_next = 1'b0;
			tick_next  = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_reg <= 1'b0;
			tick_reg  <= 1'b0;
		end
		else
		begin
			phase_reg <= phase_next;
			tick_reg  <= tick_next;
		end
	end

	assign tif.tick = tick_reg;

	// ==========================================================
	// Checks
	property p_tick_div;
		@(posedge core_clk) disable iff (!rst_n)
		(tif.host_mode && tif.div_sel && $stable(tif.div_sel) && tick_reg) |=> !tick_reg;
	endproperty
	a_tick_div: assert property (p_tick_div) else $error("sync tick not halved in host divide mode");

endmodule

/* File: rstseq_tick_if.sv */
// Sync clock tick carrier between the sequencer and its tick generator.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
interface rstseq_tick_if;
	logic host_mode;
	logic div_sel;
	logic tick;
	modport gen  (input host_mode, input div_sel, output tick);
	modport user (output host_mode, output div_sel, input tick);
endinterface
